/* File: hdl/phy_ctrl_cfg.svh */
/*
 register offsets, field positions, reset values and timing counts of the phy mode
 control and interrupt block. assumes a management access port on core_clk.
*/
// Behaviour
// - led active level from strap at reset: low strap active high, high active low
// - software forces leds through register 18h; reads never show live pins
// - half duplex: carrier sense on transmit or receive activity
// - full duplex: no collision reporting; carrier sense only on receive
// - every other mii signal identical in both duplex modes
// - fiber mode duplex comes from bit 8 of register 00h
// - fiber strap loads ability strap a into bit 8; others ignored
// - bit 14 of 00h loops transmit data to receive, nothing to medium
// - loopback state shown in bit 3 of status 10h
// - after reset pin is power-down input; 11h bit 0 makes it irq output
// - pin as input and low means power-down like 00h bit 11
// - management still answers in power-down; output enable exits it
// - irq off after reset; 11h bit 1 enables, gated by 12h low byte mask
// - enabled pending interrupt drives pin low without a clock edge
// - 12h upper byte shows pending; a read of it clears all and releases pin unless a source rises that cycle
// - 0003h to 11h sets both enables; 0060h to 12h unmasks energy and link
// - energy detect: idle stays low power with periodic pulses; activity wakes
// - diagnostics registers are page 2, chosen through page select 13h
// - polarity inversion in 10h bit 12 and 1ah bit 4
// - polarity valid only in 10 mb or negotiated 100 mb
// - crossed pairs shown in 10h bit 14, clear for normal
// - cable length estimate at page 2 14h, valid at 100 mb with link
`ifndef PHY_CTRL_CFG_SVH
`define PHY_CTRL_CFG_SVH

`define OFS_BASIC_MODE_CONTROL 5'h00
`define OFS_PHY_STATUS 5'h10
`define OFS_INTERRUPT_CONTROL 5'h11
`define OFS_INTERRUPT_STATUS_MASK 5'h12
`define OFS_PAGE_SELECT 5'h13
`define OFS_CABLE_LENGTH_ESTIMATE 5'h14
`define OFS_LED_DIRECT_CONTROL 5'h18
`define OFS_TEN_MB_STATUS_CONTROL 5'h1a
`define OFS_ENERGY_DETECT_CONTROL 5'h1d

`define BMC_LOOPBACK 14
`define BMC_POWER_DOWN 11
`define BMC_DUPLEX 8
`define STS_MDIX 14
`define STS_POLARITY 12
`define STS_LOOPBACK 3
`define TEN_POLARITY 4
`define ICTL_PIN_OE 0
`define ICTL_IRQ_EN 1
`define EDC_ENABLE 15
`define PAGE_DIAG 3'h2

`define SRC_ENERGY 6
`define SRC_LINK 5

`define BMC_RESET 16'h3100
`define ICTL_RESET 16'h0000
`define MASK_RESET 8'h00
`define EDC_RESET 16'h0000

`define ED_PULSE_PERIOD_US 10
`define ED_PULSE_PERIOD_CYC (`ED_PULSE_PERIOD_US * 100)

`endif

/* File: hdl/phy_ctrl_pkg.sv */
/*
 types of the phy mode control and interrupt block.
 assumes nothing beyond a single clock domain.
*/
package phy_ctrl_pkg;

typedef enum logic [2:0] {
    ED_OFF = 3'b001,
    ED_SLEEP = 3'b010,
    ED_AWAKE = 3'b100
} ed_state_t;

typedef struct packed {
    logic [3:0] txd;
    logic txEn;
} mii_tx_t;

typedef struct packed {
    logic [3:0] rxd;
    logic rxDv;
    logic crs;
    logic col;
} mii_rx_t;

typedef struct packed {
    logic [15:0] bmc;
    logic [15:0] ictl;
    logic [7:0] pend;
    logic [7:0] mask;
    logic [2:0] page;
    logic [15:0] ledCtl;
    logic [15:0] edc;
    logic [2:0] ledPolLow;
    logic strapDone;
    logic [1:0] pinSync;
    logic [7:0] srcPrev;
    logic [15:0] rdData;
    ed_state_t edState;
    logic [15:0] edCnt;
    logic edPulse;
    logic [2:0] ledOut;
    mii_rx_t rx;
    mii_tx_t mediaTx;
} state_t;

endpackage : phy_ctrl_pkg

/* File: hdl/phy_mode_control.sv */
/*
 management registers, duplex, loopback, power-down/interrupt pin, energy detect,
 leds and diagnostics status of a single port transceiver.
 assumes the management frame engine presents one-cycle read/write strobes on core_clk
 and the analog side supplies link, activity and diagnostics levels on core_clk.
*/
`timescale 1ns/10ps
`include "phy_ctrl_cfg.svh"

module phy_mode_control (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic mgmtWrite,
    input wire logic mgmtRead,
    input wire logic [4:0] mgmtAddr,
    input wire logic [15:0] mgmtWdata,
    output logic [15:0] mgmtRdata,
    input wire logic [2:0] ledStrapIn,
    input wire logic neg_ability_strap_a,
    input wire logic neg_ability_strap_b,
    input wire logic neg_enable_strap,
    input wire logic fiber_mode_strap_pin,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe_n,
    input wire logic [7:0] irqSources,
    input wire logic lineEnergy,
    input wire logic linkUp,
    input wire logic speed100,
    input wire logic autoNegotiated,
    input wire logic polarityInv,
    input wire logic mdixActive,
    input wire logic [7:0] cableLength,
    input wire logic [2:0] ledFunction,
    input wire phy_ctrl_pkg::mii_tx_t miiTx,
    input wire phy_ctrl_pkg::mii_rx_t mediaRx,
    output phy_ctrl_pkg::mii_rx_t miiRx,
    output phy_ctrl_pkg::mii_tx_t mediaTx,
    output logic [2:0] ledOut,
    output logic powerDown,
    output logic edPulse,
    output logic fullDuplex
);
    import phy_ctrl_pkg::*;

    state_t s_reg;
    state_t s_next;
    logic [7:0] pendVisible;
    logic irqActive;
    logic pinPowerDown;

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    function automatic logic [15:0] readMux(input state_t s, input logic [4:0] a,
                                            input logic [15:0] stsWord,
                                            input logic [7:0] cableLen,
                                            input logic polOk);
        logic [15:0] d;
        d = 16'h0000;
        if (s.page == `PAGE_DIAG && a == `OFS_CABLE_LENGTH_ESTIMATE) begin
            d = {8'h00, cableLen};
        end else begin
            unique case (a)
                `OFS_BASIC_MODE_CONTROL: d = s.bmc;
                `OFS_PHY_STATUS: d = stsWord;
                `OFS_INTERRUPT_CONTROL: d = s.ictl;
                `OFS_INTERRUPT_STATUS_MASK: d = {s.pend, s.mask};
                `OFS_PAGE_SELECT: d = {13'h0000, s.page};
                `OFS_LED_DIRECT_CONTROL: d = s.ledCtl;
                `OFS_TEN_MB_STATUS_CONTROL: d = {11'h000, polOk, 4'h0};
                `OFS_ENERGY_DETECT_CONTROL: d = s.edc;
                default: d = 16'h0000;
            endcase
        end
        return d;
    endfunction : readMux

    logic polValid;
    logic [15:0] statusWord;
    logic cableValid;

    always_comb begin
        polValid = polarityInv & (~speed100 | autoNegotiated);
        cableValid = speed100 & linkUp;
        statusWord = 16'h0000;
        statusWord[`STS_MDIX] = mdixActive;
        statusWord[`STS_POLARITY] = polValid;
        statusWord[`STS_LOOPBACK] = s_reg.bmc[`BMC_LOOPBACK];
        statusWord[2] = s_reg.edState == ED_SLEEP;
        statusWord[1] = speed100;
        statusWord[0] = linkUp;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rise;
        logic rdStatus;
        logic duplex;
        rise = 8'h00;
        rdStatus = 1'b0;
        duplex = 1'b0;
        s_next = s_reg;
        s_next.pinSync = {s_reg.pinSync[0], pinIn};
        s_next.srcPrev = irqSources;
        s_next.edPulse = 1'b0;
        // straps are caught once after reset release
        if (!s_reg.strapDone) begin
            s_next.strapDone = 1'b1;
            s_next.ledPolLow = ledStrapIn;
            if (fiber_mode_strap_pin) begin
                s_next.bmc[`BMC_DUPLEX] = neg_ability_strap_a;
                s_next.bmc[12] = 1'b0;
            end else begin
                s_next.bmc[12] = neg_enable_strap;
                s_next.bmc[`BMC_DUPLEX] = neg_ability_strap_b;
            end
        end
        // register writes, answered even in power-down
        if (mgmtWrite) begin
            unique case (mgmtAddr)
                `OFS_BASIC_MODE_CONTROL: s_next.bmc = mgmtWdata;
                `OFS_INTERRUPT_CONTROL: s_next.ictl = mgmtWdata;
                `OFS_INTERRUPT_STATUS_MASK: s_next.mask = mgmtWdata[7:0];
                `OFS_PAGE_SELECT: s_next.page = mgmtWdata[2:0];
                `OFS_LED_DIRECT_CONTROL: s_next.ledCtl = mgmtWdata;
                `OFS_ENERGY_DETECT_CONTROL: s_next.edc = mgmtWdata;
                default: s_next.ledCtl = s_next.ledCtl;
            endcase
        end
        if (mgmtRead) begin
            s_next.rdData = readMux(s_reg, mgmtAddr, statusWord, cableValid ? cableLength :
                                    8'h00, polValid);
            rdStatus = (mgmtAddr == `OFS_INTERRUPT_STATUS_MASK) &&
                       !(s_reg.page == `PAGE_DIAG && mgmtAddr == `OFS_CABLE_LENGTH_ESTIMATE);
        end
        // pending flags: a new event beats the read clear
        rise = irqSources & ~s_reg.srcPrev;
        s_next.pend = (rdStatus ? 8'h00 : s_reg.pend) | rise;
        // energy detect: sleep on idle line, pulse periodically, wake on energy
        unique case (s_reg.edState)
            ED_OFF: begin
                if (s_reg.edc[`EDC_ENABLE] && !lineEnergy) begin
                    s_next.edState = ED_SLEEP;
                    s_next.edCnt = 16'h0000;
                end
            end
            ED_SLEEP: begin
                if (!s_reg.edc[`EDC_ENABLE]) begin
                    s_next.edState = ED_OFF;
                end else if (lineEnergy) begin
                    s_next.edState = ED_AWAKE;
                end else if (s_reg.edCnt == 16'(`ED_PULSE_PERIOD_CYC - 1)) begin
                    s_next.edCnt = 16'h0000;
                    s_next.edPulse = 1'b1;
                end else begin
                    s_next.edCnt = s_reg.edCnt + 16'h0001;
                end
            end
            ED_AWAKE: begin
                if (!s_reg.edc[`EDC_ENABLE] || !lineEnergy) begin
                    s_next.edState = s_reg.edc[`EDC_ENABLE] ? ED_SLEEP : ED_OFF;
                    s_next.edCnt = 16'h0000;
                end
            end
            default: s_next.edState = ED_OFF;
        endcase
        // leds: direct override bits [2:0] with values in [5:3]
        for (int i = 0; i < 3; i++) begin
            logic on;
            on = s_reg.ledCtl[i] ? s_reg.ledCtl[i + 3] : ledFunction[i];
            s_next.ledOut[i] = on ^ s_reg.ledPolLow[i];
        end
        // mii path
        duplex = s_reg.bmc[`BMC_DUPLEX];
        if (s_reg.bmc[`BMC_LOOPBACK]) begin
            s_next.rx.rxd = miiTx.txd;
            s_next.rx.rxDv = miiTx.txEn;
            s_next.mediaTx = '0;
        end else begin
            s_next.rx.rxd = mediaRx.rxd;
            s_next.rx.rxDv = mediaRx.rxDv;
            s_next.mediaTx = miiTx;
        end
        if (duplex) begin
            s_next.rx.crs = s_next.rx.rxDv | mediaRx.crs;
            s_next.rx.col = 1'b0;
        end else begin
            s_next.rx.crs = s_next.rx.rxDv | mediaRx.crs | miiTx.txEn;
            s_next.rx.col = miiTx.txEn & (mediaRx.crs | mediaRx.rxDv) &
                            ~s_reg.bmc[`BMC_LOOPBACK];
        end
        if (srst) begin
            s_next = '0;
            s_next.bmc = `BMC_RESET;
            s_next.ictl = `ICTL_RESET;
            s_next.mask = `MASK_RESET;
            s_next.edc = `EDC_RESET;
            s_next.edState = ED_OFF;
            s_next.pinSync = 2'b11;
            // a source already high at release is no event
            s_next.srcPrev = irqSources;
        end
    end

    always_ff @(posedge core_clk) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // pin and outputs
    // ------------------------------------------------------------
    always_comb begin
        pendVisible = s_reg.pend & s_reg.mask;
        irqActive = s_reg.ictl[`ICTL_IRQ_EN] & (|pendVisible);
        pinPowerDown = ~s_reg.ictl[`ICTL_PIN_OE] & ~s_reg.pinSync[1];
        pinOe_n = ~s_reg.ictl[`ICTL_PIN_OE];
        pinOut = ~irqActive;
    end

    assign mgmtRdata = s_reg.rdData;
    assign powerDown = s_reg.bmc[`BMC_POWER_DOWN] | pinPowerDown;
    assign edPulse = s_reg.edPulse;
    assign fullDuplex = s_reg.bmc[`BMC_DUPLEX];
    assign miiRx = s_reg.rx;
    assign mediaTx = s_reg.mediaTx;
    assign ledOut = s_reg.ledOut;

endmodule : phy_mode_control

/* File: verif/mgmt_host_model.sv */
/*
 management controller model: one-cycle read and write strobes on core_clk.
 assumes the block takes a request on the edge where its strobe is high.
*/
`timescale 1ns/10ps
module mgmt_host_model (
    input wire logic core_clk,
    output logic mgmtWrite,
    output logic mgmtRead,
    output logic [4:0] mgmtAddr,
    output logic [15:0] mgmtWdata,
    input wire logic [15:0] mgmtRdata
);
    // ------
    // request driver
    // ------
    initial begin
        mgmtWrite = 1'b0;
        mgmtRead = 1'b0;
        mgmtAddr = 5'h1f;
        mgmtWdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge core_clk);
        mgmtWrite <= w;
        mgmtRead <= !w;
        mgmtAddr <= a;
        mgmtWdata <= d;
        @(posedge core_clk);
        mgmtWrite <= 1'b0;
        mgmtRead <= 1'b0;
        // released lines never show the last value
        mgmtAddr <= ~a;
        mgmtWdata <= ~d;
        @(posedge core_clk);
        q = mgmtRdata;
    endtask : xfer
endmodule : mgmt_host_model

/* File: verif/phy_mode_chk.sv */
/*
 port checker of phy_mode_control.
 assumes one clock core_clk and srst synchronous, active high.
*/
`timescale 1ns/10ps
module phy_mode_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic mgmtWrite,
    input wire logic mgmtRead,
    input wire logic [4:0] mgmtAddr,
    input wire logic [15:0] mgmtWdata,
    input wire logic [15:0] mgmtRdata,
    input wire logic pinIn,
    input wire logic pinOut,
    input wire logic pinOe_n,
    input wire logic [7:0] irqSources,
    input wire phy_ctrl_pkg::mii_tx_t miiTx,
    input wire phy_ctrl_pkg::mii_rx_t mediaRx,
    input wire phy_ctrl_pkg::mii_rx_t miiRx,
    input wire phy_ctrl_pkg::mii_tx_t mediaTx,
    input wire logic powerDown,
    input wire logic fullDuplex
);
    // ------
    // loopback shadow and assertions
    // ------
    logic lpbk_reg;
    always_ff @(posedge core_clk) begin
        if (srst)
            lpbk_reg <= 1'b0;
        else if (mgmtWrite && mgmtAddr == 5'h00)
            lpbk_reg <= mgmtWdata[14];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence pinLow_s;
        (pinOe_n && !pinIn) [*3];
    endsequence
    pin_mode_a: assert property (
        mgmtWrite && mgmtAddr == 5'h11 |=> pinOe_n == !$past(mgmtWdata[0]))
        else $error("pin enable does not follow control write");
    pin_down_a: assert property (pinLow_s |-> powerDown)
        else $error("low pin input gave no power-down");
    read_release_a: assert property (
        mgmtRead && mgmtAddr == 5'h12 && !(|(irqSources & ~$past(irqSources))) |=> pinOut)
        else $error("status read did not release pin");
    irq_hold_a: assert property (!pinOut && !mgmtRead && !mgmtWrite |=> !pinOut)
        else $error("pending interrupt lost before read");
    loop_data_a: assert property (
        lpbk_reg |=> miiRx.rxd == $past(miiTx.txd) && !mediaTx.txEn)
        else $error("loopback data path wrong");
    loop_status_a: assert property (
        mgmtRead && mgmtAddr == 5'h10 |=> mgmtRdata[3] == $past(lpbk_reg))
        else $error("loopback status bit wrong");
    full_sense_a: assert property (
        fullDuplex && !lpbk_reg && !powerDown |=> !miiRx.col &&
        miiRx.crs == ($past(mediaRx.crs) || $past(mediaRx.rxDv)))
        else $error("full duplex sense or collision wrong");
    half_sense_a: assert property (
        !fullDuplex && !lpbk_reg && !powerDown |=> miiRx.crs ==
        ($past(mediaRx.crs) || $past(mediaRx.rxDv) || $past(miiTx.txEn)))
        else $error("half duplex carrier sense wrong");
    rx_pass_a: assert property (
        !lpbk_reg && !powerDown |=> miiRx.rxd == $past(mediaRx.rxd))
        else $error("receive data not passed through");
endmodule : phy_mode_chk

bind phy_mode_control phy_mode_chk chk (.*);

/* File: verif/phy_mode_control_tb_top.sv */
/*
 self-checking testbench of phy_mode_control with the host model and checker.
 assumes package, design, model and checker compiled before it.
*/
`timescale 1ns/10ps
module phy_mode_control_tb_top;
    import phy_ctrl_pkg::*;
    // ------
    // stimulus and checks
    // ------
    logic core_clk = 1'b0, srst = 1'b1, mgmtWrite, mgmtRead, pinOut, pinOe_n, pdIn = 1'b1;
    logic [4:0] mgmtAddr;
    logic [15:0] mgmtWdata, mgmtRdata, q;
    logic [2:0] ledStrapIn = 3'h0, ledFunction = 3'h0, ledOut;
    logic neg_ability_strap_a = 1'b0, neg_ability_strap_b = 1'b1, neg_enable_strap = 1'b1;
    logic fiber_mode_strap_pin = 1'b1, lineEnergy = 1'b1, linkUp = 1'b0, speed100 = 1'b0;
    logic autoNegotiated = 1'b0, polarityInv = 1'b0, mdixActive = 1'b0;
    logic powerDown, edPulse, fullDuplex;
    logic [7:0] irqSources = 8'h00, cableLength = 8'h00, r;
    mii_tx_t miiTx = '0, mediaTx;
    mii_rx_t mediaRx = '0, miiRx;
    int checks = 0, fails = 0, n;
    wire pinWire = pinOe_n ? pdIn : pinOut;
    phy_mode_control uut (.pinIn(pinWire), .*);
    mgmt_host_model hm (.*);
    always #5 core_clk = ~core_clk;
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        hm.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        hm.xfer(1'b0, a, 16'h0000, q);
    endtask : rd
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic pulses(input int len);
        n = 0;
        repeat (len) begin
            @(negedge core_clk);
            n += (edPulse === 1'b1);
        end
    endtask : pulses
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    function automatic logic pinExp(input logic [7:0] p);
        return !(|(p & 8'h60));
    endfunction : pinExp
    initial begin
        ledStrapIn <= 3'($urandom(32'h7c5d1b48));
        tick(20);
        srst <= 1'b0;
        tick(2);
        rd(5'h00);
        chk("duplex bit", q[8], 1'b0);
        rd(5'h11);
        chk("irq control", q, 16'h0000);
        chk("pin enable", pinOe_n, 1'b1);
        r = 8'($urandom);
        ledFunction <= r[5:3];
        tick(2);
        chk("led", ledOut, r[5:3] ^ ledStrapIn);
        wr(5'h18, {10'h000, r[2:0], 3'h7});
        tick(1);
        chk("led forced", ledOut, r[2:0] ^ ledStrapIn);
        rd(5'h18);
        chk("led reg", q, {10'h000, r[2:0], 3'h7});
        wr(5'h18, 16'h0000);
        $display("test led done");
        wr(5'h11, 16'h0003);
        wr(5'h12, 16'h0060);
        chk("pin enable", pinOe_n, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 8'h20 : (i == 1) ? 8'h01 : 8'($urandom);
            irqSources <= 8'h00;
            tick(2);
            irqSources <= r;
            tick(5);
            chk("irq pin", pinOut, pinExp(r));
            rd(5'h12);
            chk("pending", q, {r, 8'h60});
            chk("pin released", pinOut, 1'b1);
        end
        wr(5'h11, 16'h0000);
        pdIn <= 1'b0;
        tick(4);
        chk("power down", powerDown, 1'b1);
        rd(5'h12);
        chk("mgmt in power down", q, 16'h0060);
        wr(5'h11, 16'h0001);
        tick(1);
        chk("power up", powerDown, 1'b0);
        pdIn <= 1'b1;
        wr(5'h11, 16'h0000);
        $display("test interrupt done");
        miiTx <= {r[3:0], 1'b1};
        mediaRx <= {4'h5, 1'b0, 1'b0, 1'b1};
        wr(5'h00, 16'h0100);
        tick(1);
        chk("full duplex", fullDuplex, 1'b1);
        chk("full crs col", {miiRx.crs, miiRx.col}, 2'b00);
        chk("rx data", miiRx.rxd, 4'h5);
        chk("tx pass", mediaTx, {r[3:0], 1'b1});
        wr(5'h00, 16'h0000);
        tick(1);
        chk("half crs col", {miiRx.crs, miiRx.col}, 2'b10);
        wr(5'h00, 16'h4000);
        tick(1);
        chk("loop data", {miiRx.rxd, mediaTx.txEn}, {r[3:0], 1'b0});
        rd(5'h10);
        chk("loop status", q[3], 1'b1);
        wr(5'h00, 16'h0000);
        $display("test duplex done");
        for (int v = 0; v < 2; v++) begin
            polarityInv <= 1'b1;
            mdixActive <= !v[0];
            linkUp <= 1'b1;
            speed100 <= !v[0];
            cableLength <= 8'($urandom);
            rd(5'h10);
            chk("pol mdix", {q[14], q[12]}, {!v[0], v[0]});
            rd(5'h1a);
            chk("ten pol", q[4], v[0]);
            wr(5'h13, 16'h0002);
            rd(5'h14);
            chk("cable", q, v[0] ? 16'h0000 : {8'h00, cableLength});
            wr(5'h13, 16'h0000);
        end
        wr(5'h1d, 16'h8000);
        lineEnergy <= 1'b0;
        for (n = 0; n < 1100 && edPulse !== 1'b1; n++) @(negedge core_clk);
        pulses(1500);
        chk("sleep pulses", 16'(n), 16'h0001);
        @(posedge core_clk);
        lineEnergy <= 1'b1;
        pulses(1500);
        chk("awake pulses", 16'(n), 16'h0000);
        $display("test status done");
        give_verdict();
    end
    // the tests need under 10000 cycles, so 50000 means a hang
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
endmodule : phy_mode_control_tb_top
